/* pkg/tpot_consts.vh */
`ifndef TPOT_CONSTS_VH
`define TPOT_CONSTS_VH

// ------------------------------------------------
// Slave address
// ------------------------------------------------
// Arbitrary value
`define TPOT_TYPE_ID 4'h6
// Undocumented fourth address bit
`define TPOT_ADDR_BIT1 1'b0

// ------------------------------------------------
// Command byte fields and opcodes
// ------------------------------------------------
`define TPOT_ID_HI 7
`define TPOT_ID_LO 4
`define TPOT_SEL_HI 3
`define TPOT_SEL_LO 2
`define TPOT_LOW_HI 1
`define TPOT_LOW_LO 0
`define TPOT_OP_RD_WPR 4'h9
`define TPOT_OP_WR_WPR 4'ha
`define TPOT_OP_RD_SSR 4'hb
`define TPOT_OP_WR_SSR 4'hc
`define TPOT_OP_SSR2WPR 4'hd
`define TPOT_OP_WPR2SSR 4'he
`define TPOT_OP_INCDEC 4'h2

// ------------------------------------------------
// Wiper and stored settings
// ------------------------------------------------
`define TPOT_WPR_MAX 6'h3f
`define TPOT_WPR_MIN 6'h00
`define TPOT_SSR_INIT 24'h000000
`define TPOT_SSR_W 6
`define TPOT_TAPS 64

// ------------------------------------------------
// Byte phases and timing
// ------------------------------------------------
`define TPOT_BIT_LAST 4'h8
`define TPOT_BIT_ACK 4'h9
`define TPOT_MCLK_MHZ 20'd10
`define TPOT_NVWR_US 20'd5000
`define TPOT_NVMAX_US 20'd10000

`endif

/* hdl/tpot_line_sync.v */
`timescale 1ns/1ps
`default_nettype none
module tpot_line_sync (
    input wire mclk,              // System clock
    input wire rst_n,             // Synchronous reset, active low
    input wire [5:0] rawIn,       // {straps[2:0], wpN, sda, scl}
    output wire [5:0] syncOut,    // Synchronised copies
    output wire sclRise,          // Clock rose
    output wire sclFall,          // Clock fell
    output wire startDet,         // Start seen
    output wire stopDet           // Stop seen
);
    // ------------------------------------------------
    // Two-stage synchronisers
    // ------------------------------------------------
    reg [5:0] meta_r;
    reg [5:0] sync_r;
    reg [1:0] prev_r;
    genvar i;
    generate
        for (i = 0; i < 6; i = i + 1) begin : gSync
            always @(posedge mclk) begin
                if (!rst_n) begin
                    meta_r[i] <= 1'b1;
                    sync_r[i] <= 1'b1;
                end else begin
                    meta_r[i] <= rawIn[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    // ------------------------------------------------
    // Edge and condition detection
    // ------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_n) begin
            prev_r <= 2'h3;
        end else begin
            prev_r <= sync_r[1:0];
        end
    end

    assign syncOut = sync_r;
    assign sclRise = sync_r[0] & ~prev_r[0];
    assign sclFall = ~sync_r[0] & prev_r[0];
    // Data edge with clock held high is a condition, not data
    assign startDet = sync_r[0] & prev_r[0] & prev_r[1] & ~sync_r[1];
    assign stopDet = sync_r[0] & prev_r[0] & ~prev_r[1] & sync_r[1];
endmodule // tpot_line_sync
`default_nettype wire

/* hdl/tpot_slave.v */
`timescale 1ns/1ps
`default_nettype none
`include "tpot_consts.vh"
module tpot_slave #(
    parameter [19:0] NV_WRITE_CYCLES = `TPOT_NVWR_US * `TPOT_MCLK_MHZ
) (
    input wire mclk,                     // System clock, 10 MHz
    input wire rst_n,                    // Synchronous reset, active low
    input wire scl,                      // Serial clock pin
    input wire sdaIn,                    // Serial data pin level
    output wire sdaOut,                  // Serial data drive value
    output wire sdaOe,                   // High while pulling data low
    input wire [2:0] addrStrapPins,      // Address straps {A3,A2,A0}
    input wire wpN,                      // Write protect, active low
    output wire [5:0] wiperPositionReg,  // Current wiper position
    output wire [63:0] tapSel,           // One-hot tap switch select
    output wire nvBusy                   // Nonvolatile write running
);
    // ------------------------------------------------
    // States
    // ------------------------------------------------
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_CMD = 3'h2;
    localparam [2:0] S_WDATA = 3'h3;
    localparam [2:0] S_RDATA = 3'h4;
    localparam [2:0] S_INCDEC = 3'h5;
    localparam [19:0] NV_LOAD = NV_WRITE_CYCLES - 20'd1;

    wire [5:0] syncV;
    wire sclRise;
    wire sclFall;
    wire startDet;
    wire stopDet;
    wire sdaS = syncV[1];
    wire wpS = syncV[2];
    wire [2:0] strapS = syncV[5:3];

    reg [2:0] state_r;
    reg [3:0] bitCnt_r;
    reg [7:0] shift_r;
    reg [7:0] tx_r;
    reg pullLow_r;
    reg ackThis_r;
    reg [3:0] op_r;
    reg [1:0] sel_r;
    reg [5:0] wiper_r;
    reg [23:0] ssr_r;
    reg pend_r;
    reg [1:0] pendSel_r;
    reg [5:0] pendData_r;
    reg busy_r;
    reg [19:0] busyCnt_r;
    reg recall_r;
    reg [63:0] tap_r;

    tpot_line_sync uSync (
        .mclk(mclk),
        .rst_n(rst_n),
        .rawIn({addrStrapPins, wpN, sdaIn, scl}),
        .syncOut(syncV),
        .sclRise(sclRise),
        .sclFall(sclFall),
        .startDet(startDet),
        .stopDet(stopDet)
    );

    // ------------------------------------------------
    // Byte decode
    // ------------------------------------------------
    wire [3:0] expAddr = {strapS[2], strapS[1], `TPOT_ADDR_BIT1, strapS[0]};
    wire idOk = shift_r[`TPOT_ID_HI:`TPOT_ID_LO] == `TPOT_TYPE_ID;
    wire addrOk = shift_r[`TPOT_SEL_HI:`TPOT_LOW_LO] == expAddr;
    wire [3:0] opIn = shift_r[`TPOT_ID_HI:`TPOT_ID_LO];
    wire [1:0] selIn = shift_r[`TPOT_SEL_HI:`TPOT_SEL_LO];
    wire lowZero = shift_r[`TPOT_LOW_HI:`TPOT_LOW_LO] == 2'h0;
    reg cmdOk;
    always @* begin
        case (opIn)
            `TPOT_OP_RD_WPR,
            `TPOT_OP_WR_WPR: cmdOk = lowZero & (selIn == 2'h0);
            `TPOT_OP_RD_SSR,
            `TPOT_OP_WR_SSR,
            `TPOT_OP_SSR2WPR,
            `TPOT_OP_WPR2SSR: cmdOk = lowZero;
            // Lowest bit is don't-care for inc/dec
            `TPOT_OP_INCDEC: cmdOk = (selIn == 2'h0) & ~shift_r[`TPOT_LOW_HI];
            default: cmdOk = 1'b0;
        endcase
    end
    wire [5:0] ssrSelOut = ssr_r[selIn * `TPOT_SSR_W +: `TPOT_SSR_W];

    // ------------------------------------------------
    // Protocol engine
    // ------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            bitCnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            pullLow_r <= 1'b0;
            ackThis_r <= 1'b0;
            op_r <= 4'h0;
            sel_r <= 2'h0;
            wiper_r <= `TPOT_WPR_MIN;
            ssr_r <= `TPOT_SSR_INIT;
            pend_r <= 1'b0;
            pendSel_r <= 2'h0;
            pendData_r <= 6'h00;
            busy_r <= 1'b0;
            busyCnt_r <= 20'h00000;
            recall_r <= 1'b1;
        end else begin
            recall_r <= 1'b0;
            if (recall_r) begin
                wiper_r <= ssr_r[`TPOT_SSR_W-1:0];
            end
            if (busy_r) begin
                if (busyCnt_r == 20'h00000) begin
                    busy_r <= 1'b0;
                end else begin
                    busyCnt_r <= busyCnt_r - 20'd1;
                end
            end
            if (startDet) begin
                // Polling during a write restarts here too
                state_r <= S_ADDR;
                bitCnt_r <= 4'h0;
                pullLow_r <= 1'b0;
            end else if (stopDet) begin
                state_r <= S_IDLE;
                pullLow_r <= 1'b0;
                if (pend_r) begin
                    pend_r <= 1'b0;
                    // Protected write is acked but leaves no trace
                    if (wpS) begin
                        ssr_r[pendSel_r * `TPOT_SSR_W +: `TPOT_SSR_W] <= pendData_r;
                        busy_r <= 1'b1;
                        busyCnt_r <= NV_LOAD;
                    end
                end
            end else if (sclRise) begin
                if (state_r == S_INCDEC) begin
                    if (sdaS && wiper_r != `TPOT_WPR_MAX) begin
                        wiper_r <= wiper_r + 6'h01;
                    end else if (!sdaS && wiper_r != `TPOT_WPR_MIN) begin
                        wiper_r <= wiper_r - 6'h01;
                    end
                end else if (state_r != S_IDLE) begin
                    if (bitCnt_r < `TPOT_BIT_LAST) begin
                        shift_r <= {shift_r[6:0], sdaS};
                    end
                    if (bitCnt_r != `TPOT_BIT_ACK) begin
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end
                end
            end else if (sclFall && state_r != S_IDLE && state_r != S_INCDEC) begin
                if (bitCnt_r == `TPOT_BIT_LAST) begin
                    // Drive the ninth-clock ack, decided from the full byte
                    case (state_r)
                        S_ADDR: ackThis_r <= idOk & addrOk & ~busy_r;
                        S_CMD: ackThis_r <= cmdOk;
                        S_WDATA: ackThis_r <= 1'b1;
                        default: ackThis_r <= 1'b0;
                    endcase
                    case (state_r)
                        S_ADDR: pullLow_r <= idOk & addrOk & ~busy_r;
                        S_CMD: pullLow_r <= cmdOk;
                        S_WDATA: pullLow_r <= 1'b1;
                        default: pullLow_r <= 1'b0;
                    endcase
                end else if (bitCnt_r == `TPOT_BIT_ACK) begin
                    pullLow_r <= 1'b0;
                    bitCnt_r <= 4'h0;
                    state_r <= S_IDLE;
                    if (ackThis_r) begin
                        case (state_r)
                            S_ADDR: state_r <= S_CMD;
                            S_CMD: begin
                                op_r <= opIn;
                                sel_r <= selIn;
                                case (opIn)
                                    `TPOT_OP_RD_WPR: begin
                                        state_r <= S_RDATA;
                                        tx_r <= {1'b0, wiper_r, 1'b0};
                                        pullLow_r <= 1'b1;
                                    end
                                    `TPOT_OP_RD_SSR: begin
                                        state_r <= S_RDATA;
                                        tx_r <= {1'b0, ssrSelOut, 1'b0};
                                        pullLow_r <= 1'b1;
                                    end
                                    `TPOT_OP_WR_WPR,
                                    `TPOT_OP_WR_SSR: state_r <= S_WDATA;
                                    `TPOT_OP_SSR2WPR: wiper_r <= ssrSelOut;
                                    `TPOT_OP_WPR2SSR: begin
                                        pend_r <= 1'b1;
                                        pendSel_r <= selIn;
                                        pendData_r <= wiper_r;
                                    end
                                    `TPOT_OP_INCDEC: state_r <= S_INCDEC;
                                    default: state_r <= S_IDLE;
                                endcase
                            end
                            S_WDATA: begin
                                if (op_r == `TPOT_OP_WR_WPR) begin
                                    wiper_r <= shift_r[5:0];
                                end else begin
                                    pend_r <= 1'b1;
                                    pendSel_r <= sel_r;
                                    pendData_r <= shift_r[5:0];
                                end
                            end
                            default: state_r <= S_IDLE;
                        endcase
                    end
                end else if (state_r == S_RDATA && bitCnt_r != 4'h0) begin
                    // Shift out on the low phase only
                    pullLow_r <= ~tx_r[7];
                    tx_r <= {tx_r[6:0], 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------
    // Tap decode
    // ------------------------------------------------
    genvar t;
    generate
        for (t = 0; t < `TPOT_TAPS; t = t + 1) begin : gTap
            always @(posedge mclk) begin
                if (!rst_n) begin
                    tap_r[t] <= 1'b0;
                end else begin
                    // Widen the wiper rather than slice the loop index
                    tap_r[t] <= ({26'h0000000, wiper_r} == t);
                end
            end
        end
    endgenerate

    assign sdaOut = 1'b0;
    assign sdaOe = pullLow_r;
    assign wiperPositionReg = wiper_r;
    assign tapSel = tap_r;
    assign nvBusy = busy_r;
endmodule // tpot_slave
`default_nettype wire

/* tb/tpot_slave_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module tpot_slave_checker #(
    parameter [19:0] NV_WRITE_CYCLES = 20'd50000
) (
    input wire logic mclk,                     // System clock
    input wire logic rst_n,                    // Sync reset, active low
    input wire logic scl,                      // Bus clock
    input wire logic sdaIn,                    // Data wire level
    input wire logic sdaOut,                   // Data drive value
    input wire logic sdaOe,                    // Data pull enable
    input wire logic [2:0] addrStrapPins,      // Address straps
    input wire logic wpN,                      // Write protect
    input wire logic [5:0] wiperPositionReg,   // Wiper
    input wire logic [63:0] tapSel,            // Tap select
    input wire logic nvBusy                    // Write cycle running
);
    logic [19:0] busyCnt_r;
    logic seenStart_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Helpers: busy length, first start seen
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busyCnt_r <= 20'h00000;
            seenStart_r <= 1'b0;
        end else begin
            busyCnt_r <= nvBusy ? busyCnt_r + 20'h00001 : 20'h00000;
            if (scl && $fell(sdaIn)) seenStart_r <= 1'b1;
        end
    end
    od_drive_a: assert property (sdaOe |-> sdaOut == 1'b0)
        else $error("data line driven high");
    tap_onehot_a: assert property ($past(rst_n) |=> tapSel == (64'h1 << $past(wiperPositionReg)))
        else $error("tap select not one-hot of wiper");
    busy_len_a: assert property ($fell(nvBusy) |-> busyCnt_r == NV_WRITE_CYCLES)
        else $error("write cycle length wrong");
    busy_max_a: assert property (nvBusy |-> busyCnt_r < NV_WRITE_CYCLES)
        else $error("write cycle overran");
    busy_quiet_a: assert property (nvBusy |-> !sdaOe)
        else $error("acknowledge while busy");
    drive_low_a: assert property ($changed(sdaOe) |-> !scl)
        else $error("data drive changed with clock high");
    ack_hold_a: assert property (sdaOe && scl |=> sdaOe)
        else $error("drive dropped during clock high");
    no_start_a: assert property (!seenStart_r |-> !sdaOe)
        else $error("drive before any start");
    wp_block_a: assert property ($rose(nvBusy) |-> wpN && $past(wpN, 4))
        else $error("write cycle while protected");
    cover property ($rose(sdaOe));
    cover property ($rose(nvBusy));
    cover property (wiperPositionReg == 6'h3f);
endmodule // tpot_slave_checker
`default_nettype wire

/* tb/tpot_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bus master, clock idles high between frames
// ----------------------------------------
module tpot_host_model (
    input wire logic mclk,     // System clock
    input wire logic sdaWire,  // Resolved data wire
    output logic scl,          // Bus clock
    output logic sdaDrv        // Data drive, 1 releases
);
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic start_c();
        wt(1);
        sdaDrv <= 1'b1;
        wt(2);
        scl <= 1'b1;
        wt(4);
        sdaDrv <= 1'b0;
        wt(4);
        scl <= 1'b0;
        wt(1);
    endtask
    task automatic xbit(input logic b, output logic r);
        wt(1);
        sdaDrv <= b;
        wt(2);
        scl <= 1'b1;
        wt(3);
        r = sdaWire;
        wt(1);
        scl <= 1'b0;
        wt(1);
    endtask
    task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
        xbit(1'b1, s);
        ack = ~s;
    endtask
    task automatic stop_c();
        wt(1);
        sdaDrv <= 1'b0;
        wt(2);
        scl <= 1'b1;
        wt(4);
        sdaDrv <= 1'b1;
        wt(4);
    endtask
endmodule // tpot_host_model
`default_nettype wire

/* tb/test_tpot_slave.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tpot_consts.vh"
module test_tpot_slave;
    localparam logic [7:0] ADR = {`TPOT_TYPE_ID, 1'b1, 1'b0, `TPOT_ADDR_BIT1, 1'b1};
    logic mclk, rst_n, wpN, scl, sdaDrv, sdaOut, sdaOe, nvBusy, a;
    logic [2:0] addrStrapPins;
    logic [5:0] wiper;
    logic [63:0] tapSel;
    logic [7:0] rd;
    logic [7:0] badAdr [4] = '{8'h10, 8'h04, 8'h02, 8'h01};
    logic [7:0] badCmd [3] = '{8'ha1, 8'ha4, 8'h70};
    int nMismatch = 0;
    int checkCount = 0;
    int cycles = 0;
    // Open drain wire with pull-up
    wire sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);
    tpot_host_model host (.mclk(mclk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv));
    tpot_slave #(.NV_WRITE_CYCLES(20'd300)) uut (
        .mclk(mclk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .addrStrapPins(addrStrapPins), .wpN(wpN),
        .wiperPositionReg(wiper), .tapSel(tapSel), .nvBusy(nvBusy));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nMismatch++;
            $display("ERROR cycles expected below 20000 seen %0d", cycles);
            finishTest();
        end
    end
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finishTest();
        if (nMismatch == 0 && checkCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic frame(input logic [7:0] adr, cmd, dat, input int nb, input logic [2:0] ea);
        logic ak;
        host.start_c();
        host.xbyte(adr, rd, ak);
        check("addrAck", ak, ea[2]);
        if (nb > 1) begin
            host.xbyte(cmd, rd, ak);
            check("cmdAck", ak, ea[1]);
        end
        if (nb > 2) begin
            host.xbyte(dat, rd, ak);
            check("dataAck", ak, ea[0]);
        end
        host.stop_c();
    endtask
    task automatic readChk(input logic [7:0] cmd, exp);
        frame(ADR, cmd, 8'hff, 3, 3'b110);
        check("readData", rd, exp);
    endtask
    // Busy device withholds the address ack, then answers
    task automatic nvPoll();
        int n;
        n = 0;
        do begin
            host.start_c();
            host.xbyte(ADR, rd, a);
            host.stop_c();
            n++;
        end while (a !== 1'b1 && n < 20);
        check("pollNack", n > 1, 1'b1);
        check("pollAck", a, 1'b1);
    endtask
    initial begin
        rst_n = 1'b0;
        wpN = 1'b1;
        addrStrapPins = 3'b101;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        host.wt(4);
        check("wiper", wiper, 6'h00);
        check("tapSel", tapSel, 64'h1);
        foreach (badAdr[i]) frame(ADR ^ badAdr[i], 8'ha0, 8'h2a, 3, 3'b000);
        check("wiper", wiper, 6'h00);
        frame(ADR, 8'ha0, 8'hff, 3, 3'b111);
        host.wt(2);
        check("wiper", wiper, 6'h3f);
        check("tapSel", tapSel, 64'h8000000000000000);
        readChk(8'h90, 8'h3f);
        foreach (badCmd[i]) frame(ADR, badCmd[i], 8'h00, 2, 3'b100);
        host.start_c();
        host.xbyte(ADR, rd, a);
        host.xbyte(8'h21, rd, a);
        check("incAck", a, 1'b1);
        host.xbit(1'b1, a);
        repeat (3) host.xbit(1'b0, a);
        check("wiper", wiper, 6'h3c);
        repeat (61) host.xbit(1'b0, a);
        check("wiper", wiper, 6'h00);
        host.stop_c();
        frame(ADR, 8'hc8, 8'h15, 3, 3'b111);
        host.wt(2);
        check("nvBusy", nvBusy, 1'b1);
        nvPoll();
        frame(ADR, 8'hd8, 8'h00, 2, 3'b110);
        host.wt(2);
        check("wiper", wiper, 6'h15);
        readChk(8'hb8, 8'h15);
        frame(ADR, 8'he4, 8'h00, 2, 3'b110);
        nvPoll();
        readChk(8'hb4, 8'h15);
        wpN <= 1'b0;
        frame(ADR, 8'hc4, 8'h2a, 3, 3'b111);
        host.wt(2);
        check("nvBusy", nvBusy, 1'b0);
        readChk(8'hb4, 8'h15);
        // Restrap to the inverse pattern: old address must fall silent
        addrStrapPins <= 3'b010;
        host.wt(4);
        frame(ADR, 8'h90, 8'hff, 3, 3'b000);
        frame(ADR ^ 8'h0d, 8'h90, 8'hff, 3, 3'b110);
        check("readData", rd, 8'h15);
        finishTest();
    end
endmodule // test_tpot_slave
bind tpot_slave tpot_slave_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk (
    .mclk(mclk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrStrapPins(addrStrapPins), .wpN(wpN), .wiperPositionReg(wiperPositionReg),
    .tapSel(tapSel), .nvBusy(nvBusy));
`default_nettype wire
